// *** core/sfr_pkg.sv ***
// Purpose: Shared constants and types for the serial flash read-feature block
// Assumes: Opcodes of boot register access and dummy counts are plain defaults
// Notes:   Everything here is used only through sfr_pkg::name
`default_nettype none
package sfr_pkg;
  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_QREAD     = 8'hEB;
  localparam logic [7:0] OP_QREAD_W   = 8'hEC;
  localparam logic [7:0] OP_QDTR      = 8'hED;
  localparam logic [7:0] OP_QDTR_W    = 8'hEE;
  localparam logic [7:0] OP_READ      = 8'h03;
  localparam logic [7:0] OP_READ_W    = 8'h13;
  localparam logic [7:0] OP_BURST_LEN = 8'hC0;
  localparam logic [7:0] OP_RST_EN    = 8'h66;
  localparam logic [7:0] OP_RST       = 8'h99;
  localparam logic [7:0] OP_BREG_RD   = 8'h16;
  localparam logic [7:0] OP_BREG_WR   = 8'h17;
  localparam logic [7:0] OP_BREG_ER   = 8'h18;
  // ----------------------------------------------------------------
  // Phase lengths in bits; all-ones reset lengths in clocks
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_BITS_NARROW = 6'h18;
  localparam logic [5:0] ADDR_BITS_WIDE   = 6'h20;
  localparam logic [5:0] CMD_BITS         = 6'h08;
  localparam logic [5:0] MODE_BITS        = 6'h08;
  localparam logic [5:0] WRAP_BITS        = 6'h08;
  localparam logic [5:0] BREG_BITS        = 6'h20;
  localparam logic [3:0] ENH_RST_NARROW   = 4'h8;
  localparam logic [3:0] ENH_RST_WIDE     = 4'hA;
  // ----------------------------------------------------------------
  // Boot register layout
  // ----------------------------------------------------------------
  localparam logic [31:0] BOOT_REG_DEFAULT = 32'hFFFFFFFF;
  localparam int          BOOT_ADDR_LSB    = 4;
  localparam int          BOOT_RSVD_BIT    = 3;
  localparam int          BOOT_DLY_LSB     = 1;
  localparam int          BOOT_EN_N_BIT    = 0;
  localparam logic [5:0]  BOOT_DLY_00      = 6'h07;
  localparam logic [5:0]  BOOT_DLY_01      = 6'h09;
  localparam logic [5:0]  BOOT_DLY_10      = 6'h0B;
  localparam logic [5:0]  BOOT_DLY_11      = 6'h0D;
  // ----------------------------------------------------------------
  // Read dummy cycles after the indicator byte, by dummy count bits
  // ----------------------------------------------------------------
  localparam logic [5:0] DUMMY_DC_00 = 6'h04;
  localparam logic [5:0] DUMMY_DC_01 = 6'h06;
  localparam logic [5:0] DUMMY_DC_10 = 6'h08;
  localparam logic [5:0] DUMMY_DC_11 = 6'h0A;
  // ----------------------------------------------------------------
  // Wrap codes
  // ----------------------------------------------------------------
  localparam logic [3:0] WRAP_OFF_NIB = 4'h1;
  localparam logic [5:0] WRAP_ON_TOP  = 6'h00;
  localparam logic [31:0] WRAP_MIN    = 32'h00000008;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA,
    ST_WRAP, ST_BREG_WR, ST_BOOT, ST_IGNORE
  } sfr_state_e;
endpackage
`default_nettype wire

// *** core/sfr_read_features.sv ***
// Purpose: Read-path features of a serial quad flash: wide address commands,
//          continuous read mode, wrapped bursts and fast boot
// Assumes: Link clock and chip select are slow against clock (4+ cycles/phase)
// Notes:   Link clock and select edges are found by sampling, not clocked on
// Behaviour
// - Wide commands take and decode 32 address bits
// - Wide commands work in either address mode
// - Continuous mode for EBh-EEh, SPI and quad
// - Toggled indicator enters or keeps continuous mode
// - Untoggled indicator plus deselect leaves continuous mode
// - SPI reset: ones on one line, 8/10
// - Quad reset: ones on four lines, 8/10
// - In continuous mode frames start with address
// - Dummy count set by configuration bits 6,7
// - Wrap off at reset, kept until changed
// - Wrap inside aligned 8/16/32/64 byte block
// - Codes 00h-03h set depth, 1xh disables
// - Wrap only for quad reads as listed
// - Fast boot reads after power-up and the 66h/99h reset command, not the all-ones reset
// - Boot data after selected delay cycles
// - Boot data single or quad by enable
// - Boot address bits 31:4, bit 3 one
// - Boot delay select 7/9/11/13 cycles
// - Boot enable bit active low, default off
// - Program, erase, read boot register commands
`default_nettype none

// ----------------------------------------------------------------
// Data FIFO between array reads and the shifter
// ----------------------------------------------------------------
module sfr_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         flush,
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           rp;
    logic [AW-1:0]           wp;
    logic [AW:0]             cnt;
    logic                    rdy;
  } sfr_fifo_s;
  sfr_fifo_s q;
  sfr_fifo_s n;
  logic      push;
  logic      pop;

  assign push     = inValid & q.rdy;
  assign pop      = outReady & (q.cnt != '0);
  assign inReady  = q.rdy;
  assign outValid = q.cnt != '0;
  assign outData  = q.mem[q.rp];

  always_comb
  begin
    n = q;
    if (push)
    begin
      n.mem[q.wp] = inData;
      n.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + AW'(1);
    end
    if (pop)
      n.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + AW'(1);
    n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush)
    begin
      n.rp = '0;
      n.wp = '0;
      n.cnt = '0;
    end
    n.rdy = n.cnt != (AW+1)'(DEPTH);
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      q <= '0;
      q.rdy <= 1'b1;
    end
    else
      q <= n;
  end
endmodule

// ----------------------------------------------------------------
// Device side read-feature engine
// ----------------------------------------------------------------
module sfr_read_features #(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        sckPin,
  input  wire logic        csNPin,
  input  wire logic [3:0]  sioIn,
  output logic      [3:0]  sioOut,
  output logic      [3:0]  sioOeN,
  input  wire logic        quadCmdMode,
  input  wire logic        quadEnableBit,
  input  wire logic        wideAddrMode,
  input  wire logic        dummyCountMsb,
  input  wire logic        dummyCountLsb,
  input  wire logic [31:0] nvBootInit,
  output logic      [31:0] bootRegValue,
  output logic             enhanceActive,
  output logic             wrapEnabled,
  output logic             memReqValid,
  output logic      [31:0] memReqAddr,
  input  wire logic        memReqReady,
  input  wire logic        memRspValid,
  input  wire logic [7:0]  memRspData,
  output logic             memRspReady
);
  typedef struct packed {
    logic                sck1, sck2, sck3, cs1, cs2, cs3;
    logic [3:0]          io1, io2;
    sfr_pkg::sfr_state_e st;
    logic [5:0]          cnt, tgt;
    logic [31:0]         sh, fetchA, reqA, bootReg;
    logic [7:0]          op, outByte;
    logic [3:0]          bitsLeft, dq, oeN, rstCnt;
    logic                quad, wide, srcReg, enh, wrapOn, wrapAct, bootArm, powered;
    logic [1:0]          wrapSel;
    logic                onesOk, resetEn, fetching, reqV, outst, drop;
  } sfr_top_s;
  sfr_top_s   q;
  sfr_top_s   n;
  logic       rise, fall, csRise, csFall, flush, pop, rspAcc;
  logic       fifoValid;
  logic [7:0] fifoData;
  logic [31:0] shIn;
  logic [5:0] cnt1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] edgesFor(input logic [5:0] bits, input logic quad);
    return quad ? {2'b00, bits[5:2]} : bits;
  endfunction

  function automatic logic toggled(input logic [7:0] b);
    return b[7:4] == ~b[3:0];
  endfunction

  function automatic logic [5:0] dummyCycles(input logic msb, input logic lsb);
    case ({msb, lsb})
      2'b00:   return sfr_pkg::DUMMY_DC_00;
      2'b01:   return sfr_pkg::DUMMY_DC_01;
      2'b10:   return sfr_pkg::DUMMY_DC_10;
      default: return sfr_pkg::DUMMY_DC_11;
    endcase
  endfunction

  function automatic logic [5:0] bootDelay(input logic [1:0] sel);
    case (sel)
      2'b00:   return sfr_pkg::BOOT_DLY_00;
      2'b01:   return sfr_pkg::BOOT_DLY_01;
      2'b10:   return sfr_pkg::BOOT_DLY_10;
      default: return sfr_pkg::BOOT_DLY_11;
    endcase
  endfunction

  function automatic logic [31:0] wrapNext(input logic [31:0] a, input logic [1:0] sel,
                                           input logic en);
    logic [31:0] m;
    m = (sfr_pkg::WRAP_MIN << sel) - 32'h1;
    return en ? ((a & ~m) | ((a + 32'h1) & m)) : a + 32'h1;
  endfunction

  assign rise   = q.sck2 & ~q.sck3;
  assign fall   = ~q.sck2 & q.sck3;
  assign csRise = q.cs2 & ~q.cs3;
  assign csFall = ~q.cs2 & q.cs3;
  assign flush  = csRise | csFall;
  assign rspAcc = memRspValid & memRspReady;
  assign shIn   = q.quad ? {q.sh[27:0], q.io2} : {q.sh[30:0], q.io2[0]};
  assign cnt1   = q.cnt + 6'h01;

  sfr_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH)
  ) sfr_fifo_inst (
    .clock    (clock),
    .reset    (reset),
    .flush    (flush),
    .inValid  (rspAcc & ~q.drop),
    .inData   (memRspData),
    .inReady  (memRspReady),
    .outValid (fifoValid),
    .outData  (fifoData),
    .outReady (pop)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] byteV;
    byteV = 8'h00;
    n = q;
    pop = 1'b0;
    n.sck1 = sckPin;
    n.sck2 = q.sck1;
    n.sck3 = q.sck2;
    n.cs1 = csNPin;
    n.cs2 = q.cs1;
    n.cs3 = q.cs2;
    n.io1 = sioIn;
    n.io2 = q.io1;
    // Array fetch, one request in flight
    if (rspAcc)
    begin
      n.outst = 1'b0;
      n.drop = 1'b0;
    end
    if (q.reqV && memReqReady)
    begin
      n.reqV = 1'b0;
      n.outst = 1'b1;
      n.fetchA = wrapNext(q.fetchA, q.wrapSel, q.wrapAct);
    end
    else if (!q.reqV && !q.outst && q.fetching && memRspReady && !flush)
    begin
      n.reqV = 1'b1;
      n.reqA = q.fetchA;
    end
    if (!q.powered)
    begin
      n.powered = 1'b1;
      n.bootReg = nvBootInit;
      n.bootReg[sfr_pkg::BOOT_RSVD_BIT] = 1'b1;
      n.bootArm = ~nvBootInit[sfr_pkg::BOOT_EN_N_BIT];
    end
    if (csRise)
    begin
      n.st = sfr_pkg::ST_IDLE;
      n.oeN = 4'hF;
      n.fetching = 1'b0;
      n.drop = (q.outst & ~rspAcc) | q.reqV | (q.drop & ~rspAcc);
      if (q.onesOk && q.rstCnt == (wideAddrMode ? sfr_pkg::ENH_RST_WIDE
                                                : sfr_pkg::ENH_RST_NARROW))
        n.enh = 1'b0;
    end
    else if (csFall)
    begin
      n.cnt = '0;
      n.rstCnt = '0;
      n.onesOk = 1'b1;
      n.bitsLeft = '0;
      n.srcReg = 1'b0;
      if (q.bootArm)
      begin
        n.st = sfr_pkg::ST_BOOT;
        n.bootArm = 1'b0;
        n.quad = quadEnableBit;
        n.tgt = bootDelay(q.bootReg[sfr_pkg::BOOT_DLY_LSB +: 2]);
        n.fetchA = {q.bootReg[31:sfr_pkg::BOOT_ADDR_LSB], 4'h0};
        n.fetching = 1'b1;
        n.wrapAct = 1'b0;
      end
      else if (q.enh)
      begin
        n.st = sfr_pkg::ST_ADDR;
        n.quad = 1'b1;
        n.tgt = edgesFor(q.wide ? sfr_pkg::ADDR_BITS_WIDE : sfr_pkg::ADDR_BITS_NARROW, 1'b1);
      end
      else
      begin
        n.st = sfr_pkg::ST_CMD;
        n.quad = quadCmdMode;
        n.tgt = edgesFor(sfr_pkg::CMD_BITS, quadCmdMode);
      end
    end
    else if (!q.cs2 && rise)
    begin
      if (q.onesOk && (quadCmdMode ? &q.io2 : q.io2[0]) && q.rstCnt != 4'hF)
        n.rstCnt = q.rstCnt + 4'h1;
      else
        n.onesOk = 1'b0;
      n.sh = shIn;
      n.cnt = cnt1;
      case (q.st)
        sfr_pkg::ST_CMD:
          if (cnt1 == q.tgt)
          begin
            n.op = shIn[7:0];
            n.cnt = '0;
            n.st = sfr_pkg::ST_IGNORE;
            n.resetEn = shIn[7:0] == sfr_pkg::OP_RST_EN;
            case (shIn[7:0])
              sfr_pkg::OP_QREAD, sfr_pkg::OP_QREAD_W, sfr_pkg::OP_QDTR, sfr_pkg::OP_QDTR_W,
              sfr_pkg::OP_READ, sfr_pkg::OP_READ_W:
              begin
                n.st = sfr_pkg::ST_ADDR;
                n.wide = wideAddrMode || shIn[7:0] == sfr_pkg::OP_QREAD_W
                      || shIn[7:0] == sfr_pkg::OP_QDTR_W || shIn[7:0] == sfr_pkg::OP_READ_W;
                n.quad = shIn[7:4] == 4'hE;
                n.wrapAct = q.wrapOn && (shIn[7:0] == sfr_pkg::OP_QREAD_W
                         || (shIn[7:0] == sfr_pkg::OP_QREAD && quadCmdMode));
                n.tgt = edgesFor(n.wide ? sfr_pkg::ADDR_BITS_WIDE : sfr_pkg::ADDR_BITS_NARROW,
                                 n.quad);
              end
              sfr_pkg::OP_BURST_LEN:
              begin
                n.st = sfr_pkg::ST_WRAP;
                n.tgt = edgesFor(sfr_pkg::WRAP_BITS, q.quad);
              end
              sfr_pkg::OP_BREG_WR:
              begin
                n.st = sfr_pkg::ST_BREG_WR;
                n.tgt = edgesFor(sfr_pkg::BREG_BITS, q.quad);
              end
              sfr_pkg::OP_BREG_ER:
                n.bootReg = sfr_pkg::BOOT_REG_DEFAULT;
              sfr_pkg::OP_BREG_RD:
              begin
                n.st = sfr_pkg::ST_DATA;
                n.srcReg = 1'b1;
                n.sh = q.bootReg;
              end
              sfr_pkg::OP_RST:
                if (q.resetEn)
                begin
                  n.enh = 1'b0;
                  n.wrapOn = 1'b0;
                  n.bootArm = ~q.bootReg[sfr_pkg::BOOT_EN_N_BIT];
                end
              default:
                n.st = sfr_pkg::ST_IGNORE;
            endcase
          end
        sfr_pkg::ST_ADDR:
          if (cnt1 == q.tgt)
          begin
            n.fetchA = q.wide ? shIn : {8'h00, shIn[23:0]};
            n.fetching = 1'b1;
            n.cnt = '0;
            if (q.op == sfr_pkg::OP_READ || q.op == sfr_pkg::OP_READ_W)
              n.st = sfr_pkg::ST_DATA;
            else
            begin
              n.st = sfr_pkg::ST_MODE;
              n.tgt = edgesFor(sfr_pkg::MODE_BITS, 1'b1);
            end
          end
        sfr_pkg::ST_MODE:
          if (cnt1 == q.tgt)
          begin
            n.enh = toggled(shIn[7:0]);
            n.cnt = '0;
            n.tgt = dummyCycles(dummyCountMsb, dummyCountLsb);
            n.st = (n.tgt == '0) ? sfr_pkg::ST_DATA : sfr_pkg::ST_DUMMY;
          end
        sfr_pkg::ST_DUMMY, sfr_pkg::ST_BOOT:
          if (cnt1 == q.tgt)
            n.st = sfr_pkg::ST_DATA;
        sfr_pkg::ST_WRAP:
          if (cnt1 == q.tgt)
          begin
            n.st = sfr_pkg::ST_IGNORE;
            if (shIn[7:4] == sfr_pkg::WRAP_OFF_NIB)
              n.wrapOn = 1'b0;
            else if (shIn[7:2] == sfr_pkg::WRAP_ON_TOP)
            begin
              n.wrapOn = 1'b1;
              n.wrapSel = shIn[1:0];
            end
          end
        sfr_pkg::ST_BREG_WR:
          if (cnt1 == q.tgt)
          begin
            n.st = sfr_pkg::ST_IGNORE;
            n.bootReg = q.bootReg & {shIn[7:0], shIn[15:8], shIn[23:16], shIn[31:24]};
            n.bootReg[sfr_pkg::BOOT_RSVD_BIT] = 1'b1;
          end
        sfr_pkg::ST_DATA:
        begin
          n.sh = q.sh;
          n.cnt = q.cnt;
        end
        default:
          n.cnt = q.cnt;
      endcase
    end
    else if (!q.cs2 && fall && q.st == sfr_pkg::ST_DATA)
    begin
      if (q.bitsLeft == '0)
      begin
        if (q.srcReg)
        begin
          byteV = q.sh[7:0];
          n.sh = {q.sh[7:0], q.sh[31:8]};
        end
        else
        begin
          byteV = fifoData;
          pop = fifoValid;
        end
      end
      else
        byteV = q.outByte;
      n.dq = q.quad ? byteV[7:4] : {2'b00, byteV[7], 1'b0};
      n.oeN = q.quad ? 4'h0 : 4'hD;
      n.outByte = q.quad ? {byteV[3:0], 4'h0} : {byteV[6:0], 1'b0};
      n.bitsLeft = ((q.bitsLeft == '0) ? 4'h8 : q.bitsLeft) - (q.quad ? 4'h4 : 4'h1);
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      q <= '0;
      q.cs1 <= 1'b1;
      q.cs2 <= 1'b1;
      q.cs3 <= 1'b1;
      q.oeN <= 4'hF;
      q.bootReg <= sfr_pkg::BOOT_REG_DEFAULT;
      q.st <= sfr_pkg::ST_IDLE;
    end
    else
      q <= n;
  end

  assign sioOut        = q.dq;
  assign sioOeN        = q.oeN;
  assign bootRegValue  = q.bootReg;
  assign enhanceActive = q.enh;
  assign wrapEnabled   = q.wrapOn;
  assign memReqValid   = q.reqV;
  assign memReqAddr    = q.reqA;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  deselect_idle_a: assert property (@(posedge clock) disable iff (reset)
    csRise |=> (q.st == sfr_pkg::ST_IDLE && q.oeN == 4'hF))
    else $error("outputs not released after deselect");
  boot_start_a: assert property (@(posedge clock) disable iff (reset)
    (csFall && q.bootArm) |=> (q.st == sfr_pkg::ST_BOOT
      && q.fetchA == {q.bootReg[31:4], 4'h0} && !q.bootArm))
    else $error("boot transfer start address wrong");
  boot_delay_a: assert property (@(posedge clock) disable iff (reset)
    (csFall && q.bootArm) |=> q.tgt == bootDelay(q.bootReg[2:1]))
    else $error("boot delay count wrong");
  enh_indicator_a: assert property (@(posedge clock) disable iff (reset)
    (!q.cs2 && !csRise && !csFall && rise && q.st == sfr_pkg::ST_MODE && cnt1 == q.tgt)
      |=> q.enh == (q.sh[7:4] == ~q.sh[3:0]))
    else $error("continuous mode flag does not follow indicator");
  wide_addr_a: assert property (@(posedge clock) disable iff (reset)
    (!q.cs2 && !csRise && !csFall && rise && q.st == sfr_pkg::ST_ADDR
      && cnt1 == q.tgt && q.wide) |=> q.fetchA == q.sh)
    else $error("wide address not taken whole");
  wrap_block_a: assert property (@(posedge clock) disable iff (reset)
    (q.reqV && memReqReady && q.wrapAct) |=> q.fetchA[31:6] == $past(q.fetchA[31:6]))
    else $error("wrapped fetch left its block");
  single_lane_a: assert property (@(posedge clock) disable iff (reset)
    (q.st == sfr_pkg::ST_DATA && !q.quad && q.oeN != 4'hF) |-> q.oeN == 4'hD)
    else $error("single line output drives other lanes");
  enh_reset_a: assert property (@(posedge clock) disable iff (reset)
    (csRise && q.onesOk && q.rstCnt == (wideAddrMode ? 4'hA : 4'h8)) |=> !q.enh)
    else $error("all ones reset did not leave continuous mode");
  dummy_len_a: assert property (@(posedge clock) disable iff (reset)
    (q.st == sfr_pkg::ST_DUMMY && n.st == sfr_pkg::ST_DATA && !csRise)
      |-> q.cnt + 6'h01 == dummyCycles(dummyCountMsb, dummyCountLsb))
    else $error("dummy phase length wrong");
endmodule
`default_nettype wire

// *** bench/sfr_host_model.sv ***
// Purpose: Host link driver facing the read-feature block
// Assumes: Link clock low between frames, 16 system clocks a period
// Notes:   Lines that nobody drives toggle every cycle
`default_nettype none
module sfr_host_model (
  input  wire logic       clock,
  output logic            sckPin,
  output logic            csNPin,
  output logic      [3:0] sioIn,
  input  wire logic [3:0] sioOut,
  input  wire logic [3:0] sioOeN
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] hostData = 4'h0;
  logic       hostOe   = 1'b0;
  logic       junk     = 1'b0;
  // Dummy clocks after the indicator; the bench keeps it in step with the count bits
  int         dummyN   = int'(sfr_pkg::DUMMY_DC_00);
  initial sckPin = 1'b0;
  initial csNPin = 1'b1;
  always @(posedge clock) junk <= ~junk;
  always_comb
    for (int i = 0; i < 4; i++)
      sioIn[i] = !sioOeN[i] ? sioOut[i] : hostOe ? hostData[i] : junk;
  task automatic frame_start();
    @(negedge clock);
    csNPin = 1'b0;
    repeat (8) @(negedge clock);
  endtask
  task automatic frame_end();
    repeat (8) @(negedge clock);
    csNPin = 1'b1;
    hostOe = 1'b0;
    repeat (16) @(negedge clock);
  endtask
  // Data is left-aligned and rotates, so ten nibbles of ones stay ones
  task automatic xfer(input int n, input bit quad, input bit drv,
                      input logic [31:0] d, output logic [31:0] q);
    q = 32'h0;
    for (int k = 0; k < n; k++)
    begin
      hostOe = drv;
      hostData = quad ? d[31:28] : {3'h0, d[31]};
      d = quad ? {d[27:0], d[31:28]} : {d[30:0], d[31]};
      repeat (7) @(negedge clock);
      q = quad ? {q[27:0], sioIn} : {q[30:0], sioIn[1]};
      @(negedge clock);
      sckPin = 1'b1;
      repeat (8) @(negedge clock);
      sckPin = 1'b0;
    end
  endtask
  // An opcode of 00h is left out, as continuous mode expects
  task automatic read_frame(input logic [7:0] op, input bit qcmd, input bit wide,
                            input logic [31:0] a, input logic [7:0] ind,
                            input int nb, output logic [31:0] q);
    frame_start();
    if (op != 8'h00)
      xfer(qcmd ? 2 : 8, qcmd, 1'b1, {op, 24'h0}, q);
    xfer(wide ? 8 : 6, 1'b1, 1'b1, wide ? a : a << 8, q);
    xfer(2, 1'b1, 1'b1, {ind, 24'h0}, q);
    xfer(dummyN + 2 * nb, 1'b1, 1'b0, 32'h0, q);
    frame_end();
  endtask
  task automatic cmd_frame(input logic [7:0] op, input bit qcmd, input int n,
                           input bit drv, input logic [31:0] d, output logic [31:0] q);
    frame_start();
    xfer(qcmd ? 2 : 8, qcmd, 1'b1, {op, 24'h0}, q);
    xfer(n, qcmd, drv, d, q);
    frame_end();
  endtask
endmodule
`default_nettype wire

// *** bench/sfr_read_features_test.sv ***
// Purpose: Self-checking bench for the read-feature block
// Assumes: Array byte is address byte 3 xor byte 0; dummy count swept in t_enh
// Notes:   Stored boot value has delay select 01 and boot enabled
`default_nettype none
module sfr_read_features_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock         = 1'b0;
  logic        reset         = 1'b1;
  logic        quadCmdMode   = 1'b0;
  logic        quadEnableBit = 1'b0;
  logic        wideAddrMode  = 1'b0;
  logic        memReqReady   = 1'b1;
  logic        memRspValid   = 1'b0;
  logic [7:0]  memRspData    = 8'h00;
  logic        hs            = 1'b0;
  logic        tk            = 1'b0;
  logic [1:0]  dcSel         = 2'b00;
  logic        sckPin, csNPin, enhanceActive, wrapEnabled, memReqValid, memRspReady;
  logic [3:0]  sioIn, sioOut, sioOeN;
  logic [31:0] bootRegValue, memReqAddr, rAddr, q;
  int          error_cnt       = 0;
  int          samples_checked = 0;
  sfr_read_features #(.FIFO_DEPTH(4)) sfr_read_features_inst (
    .clock(clock), .reset(reset), .sckPin(sckPin), .csNPin(csNPin), .sioIn(sioIn),
    .sioOut(sioOut), .sioOeN(sioOeN), .quadCmdMode(quadCmdMode),
    .quadEnableBit(quadEnableBit), .wideAddrMode(wideAddrMode), .dummyCountMsb(dcSel[1]),
    .dummyCountLsb(dcSel[0]), .nvBootInit(32'h00001232), .bootRegValue(bootRegValue),
    .enhanceActive(enhanceActive), .wrapEnabled(wrapEnabled), .memReqValid(memReqValid),
    .memReqAddr(memReqAddr), .memReqReady(memReqReady), .memRspValid(memRspValid),
    .memRspData(memRspData), .memRspReady(memRspReady));
  sfr_host_model sfr_host_model_inst (.clock(clock), .sckPin(sckPin), .csNPin(csNPin),
    .sioIn(sioIn), .sioOut(sioOut), .sioOeN(sioOeN));
  initial forever #5 clock = ~clock;
  // Array: one request at a time, answered one cycle later
  always @(posedge clock)
  begin
    hs <= memReqValid && memReqReady;
    tk <= memRspValid && memRspReady;
    if (memReqValid && memReqReady)
      rAddr <= memReqAddr;
  end
  always @(negedge clock)
    if (hs)
    begin
      memReqReady <= 1'b0;
      memRspValid <= 1'b1;
      memRspData <= rAddr[31:24] ^ rAddr[7:0];
    end
    else if (tk)
    begin
      memRspValid <= 1'b0;
      memReqReady <= 1'b1;
    end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] f(input logic [31:0] a);
    return a[31:24] ^ a[7:0];
  endfunction
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_boot(input bit qe);
    quadEnableBit = qe;
    sfr_host_model_inst.frame_start();
    sfr_host_model_inst.xfer(int'(sfr_pkg::BOOT_DLY_01), qe, 1'b0, 32'h0, q);
    sfr_host_model_inst.xfer(qe ? 4 : 16, qe, 1'b0, 32'h0, q);
    chk(sioOeN, qe ? 4'h0 : 4'hD);
    chk(q[15:0], 16'h3031);
    sfr_host_model_inst.frame_end();
  endtask
  task automatic t_wrap();
    logic [31:0] a;
    logic [31:0] e;
    quadCmdMode = 1'b1;
    for (int d = 0; d < 5; d++)
    begin
      a = 32'h100 + (32'h8 << d) - 32'h2;
      e = d == 4 ? a + 32'h2 : 32'h100;
      sfr_host_model_inst.cmd_frame(sfr_pkg::OP_BURST_LEN, 1'b1, 2, 1'b1,
                                    {d == 4 ? 8'h10 : 8'(d), 24'h0}, q);
      chk(wrapEnabled, d != 4);
      sfr_host_model_inst.read_frame(sfr_pkg::OP_QREAD_W, 1'b1, 1'b1, a, 8'hFF, 3, q);
      chk(q[23:0], {f(a), f(a + 32'h1), f(e)});
    end
  endtask
  task automatic t_enh();
    logic [31:0] a;
    logic [7:0]  op;
    for (int k = 0; k < 4; k++)
    begin
      op = 8'hEB + 8'(k);
      a = {op[0] ? 8'h00 : 8'hA5, 16'h0, 8'h10 + 8'(k)};
      // Dummy clocks 4/6/8/10 for count bits 00/01/10/11
      dcSel = 2'(k);
      sfr_host_model_inst.dummyN = int'(sfr_pkg::DUMMY_DC_00) + 2 * k;
      sfr_host_model_inst.read_frame(op, 1'b1, !op[0], a, 8'hA5, 1, q);
      chk({enhanceActive, q[7:0]}, {1'b1, f(a)});
      sfr_host_model_inst.read_frame(8'h00, 1'b1, !op[0], a + 32'h1, 8'h5A, 1, q);
      chk({enhanceActive, q[7:0]}, {1'b1, f(a + 32'h1)});
      sfr_host_model_inst.read_frame(8'h00, 1'b1, !op[0], a, k[0] ? 8'h5B : 8'hFF, 1, q);
      chk({enhanceActive, q[7:0]}, {1'b0, f(a)});
    end
    dcSel = 2'b00;
    sfr_host_model_inst.dummyN = int'(sfr_pkg::DUMMY_DC_00);
  endtask
  task automatic t_rst();
    for (int m = 0; m < 2; m++)
    begin
      quadCmdMode = m[0];
      wideAddrMode = m[0];
      sfr_host_model_inst.read_frame(sfr_pkg::OP_QREAD, m[0], m[0], 32'h40, 8'h0F, 1, q);
      chk(enhanceActive, 1'b1);
      sfr_host_model_inst.frame_start();
      sfr_host_model_inst.xfer(m ? 10 : 8, m[0], 1'b1, 32'hFFFFFFFF, q);
      sfr_host_model_inst.frame_end();
      chk(enhanceActive, 1'b0);
    end
    wideAddrMode = 1'b0;
  endtask
  task automatic t_breg();
    quadCmdMode = 1'b0;
    sfr_host_model_inst.cmd_frame(sfr_pkg::OP_BREG_ER, 1'b0, 0, 1'b1, 32'h0, q);
    chk(bootRegValue, 32'hFFFFFFFF);
    sfr_host_model_inst.cmd_frame(sfr_pkg::OP_BREG_WR, 1'b0, 32, 1'b1, 32'hE0CDAB89, q);
    chk(bootRegValue, 32'h89ABCDE8);
    sfr_host_model_inst.cmd_frame(sfr_pkg::OP_BREG_RD, 1'b0, 32, 1'b0, 32'h0, q);
    chk({q[7:0], q[15:8], q[23:16], q[31:24]}, 32'h89ABCDE8);
  endtask
  initial
  begin
    repeat (100000) @(posedge clock);
    error_cnt++;
    conclude();
  end
  initial
  begin
    repeat (12) @(negedge clock);
    reset = 1'b0;
    repeat (4) @(negedge clock);
    chk(bootRegValue, 32'h0000123A);
    chk({enhanceActive, wrapEnabled}, 2'b00);
    t_boot(1'b0);
    // Reset command arms the boot read again, now on four lines
    sfr_host_model_inst.cmd_frame(sfr_pkg::OP_RST_EN, 1'b0, 0, 1'b1, 32'h0, q);
    sfr_host_model_inst.cmd_frame(sfr_pkg::OP_RST, 1'b0, 0, 1'b1, 32'h0, q);
    t_boot(1'b1);
    t_wrap();
    t_enh();
    t_rst();
    t_breg();
    conclude();
  end
endmodule
`default_nettype wire
